// [verilog/drive_defs.svh]
// Purpose: constants of the drive status parameter bank
// Assumes: included by bare name from design files
// Notes: object address, parameter numbers, field positions, lengths
`ifndef DRIVE_DEFS_SVH
`define DRIVE_DEFS_SVH

// object address of the parameter table
`define DRV_CLASS 8'h64
`define DRV_INSTANCE 8'h01

// parameter numbers
`define PAR_STATUS_FLAGS 8'h08
`define PAR_SPEED 8'h09
`define PAR_POSITION 8'h0a
`define PAR_TORQUE 8'h0e
`define PAR_PEAK_TORQUE 8'h0f
`define PAR_LOGIC_SUPPLY 8'h10
`define PAR_MOTOR_SUPPLY 8'h11
`define PAR_TEMPERATURE 8'h12
`define PAR_SELECTOR 8'h13
`define PAR_MANUFACTURE 8'h14
`define PAR_SERIAL 8'h15

// status flag bit positions
`define STAT_RUNNING_BIT 6

// transfer lengths in bytes
`define LEN_READ16 3'h2
`define LEN_READ32 3'h4
`define LEN_WRITE16 3'h3
`define LEN_WRITE32 3'h5

// control byte that asks for a write to be ignored
`define CTRL_IGNORE 8'h00

// reset values
`define POSITION_RESET 32'h0000_0000
`define TORQUE_RESET 16'h0000
`define WORD_RESET 16'h0000

`endif

// [verilog/drive_pkg.sv]
// Purpose: types of the drive status parameter bank
// Assumes: numbers live in drive_defs.svh
// Notes: status flag struct is ordered bit 15 down to bit 0
package drive_pkg;

  typedef struct packed {
    logic neg_range_limit;
    logic pos_range_limit;
    logic motor_power_was_missing;
    logic bad_target_value;
    logic manual_displacement;
    logic blocked_position_error;
    logic general_error;
    logic against_loop_direction;
    logic temperature_exceeded;
    logic drive_running;
    logic run_aborted;
    logic motor_power_present;
    logic fwd_jog_key;
    logic rev_jog_key;
    logic drag_error;
    logic target_reached;
  } status_flags_t;

  typedef struct packed {
    logic write;
    logic [7:0] class_id;
    logic [7:0] instance_id;
    logic [7:0] param;
    logic [2:0] len;
    logic [7:0] ctrl;
    logic [31:0] value;
  } req_t;

  typedef enum logic [2:0] {
    RSP_OK = 3'b000,
    RSP_IGNORED = 3'b001,
    RSP_BAD_OBJECT = 3'b010,
    RSP_BAD_PARAM = 3'b011,
    RSP_READ_ONLY = 3'b100,
    RSP_NOT_STANDSTILL = 3'b101,
    RSP_BAD_LENGTH = 3'b110
  } rsp_code_t;

  typedef struct packed {
    rsp_code_t code;
    logic [2:0] len;
    logic [31:0] data;
  } rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_ANSWER = 2'b10
  } bank_state_t;

endpackage

// [verilog/position_counter.sv]
// Purpose: present position accumulator with re-reference load
// Assumes: steps arrive as signed increments in position units
// Notes: a load takes precedence over a step in the same cycle
`timescale 1ns/1ps
`include "drive_defs.svh"

module position_counter
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // motion increments
  input wire logic step_valid,
  input wire logic signed [15:0] step,
  // re-reference
  input wire logic load,
  input wire logic [31:0] load_value,
  // result
  output logic [31:0] position
);

  logic [31:0] next_position;

  always_comb
  begin
    next_position = position;
    if (load)
    begin
      next_position = load_value;
    end
    else if (step_valid)
    begin
      next_position = position + {{16{step[15]}}, step};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      position <= `POSITION_RESET;
    end
    else if (clk_en)
    begin
      position <= next_position;
    end
  end

endmodule

// [verilog/peak_torque_tracker.sv]
// Purpose: largest torque of the most recent run
// Assumes: phase inputs come from the motion controller
// Notes: cleared when a run starts, held after the run ends
`timescale 1ns/1ps
`include "drive_defs.svh"

module peak_torque_tracker
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // run phase
  input wire logic run_active,
  input wire logic start_phase,
  input wire logic brake_phase,
  // measurement
  input wire logic [15:0] torque,
  // result
  output logic [15:0] peak
);

  logic run_seen;
  logic next_run_seen;
  logic [15:0] next_peak;

  always_comb
  begin
    next_run_seen = run_active;
    next_peak = peak;
    if (run_active && !run_seen)
    begin
      next_peak = `TORQUE_RESET;
    end
    if (run_active && !start_phase && !brake_phase)
    begin
      // start-up and braking are excluded
      if (!run_seen || torque > peak)
      begin
        next_peak = (run_seen && torque <= peak) ? peak : torque;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      run_seen <= 1'b0;
      peak <= `TORQUE_RESET;
    end
    else if (clk_en)
    begin
      run_seen <= next_run_seen;
      peak <= next_peak;
    end
  end

endmodule

// [verilog/drive_status_parameter_bank.sv]
// Purpose: acyclic read/write parameter bank of a positioning drive
// Assumes: one request at a time, taken when req_ready is high
// Notes: answers two edges after the request edge
`timescale 1ns/1ps
`include "drive_defs.svh"

module drive_status_parameter_bank
#(
  parameter logic [15:0] MANUFACTURE_YYWW = 16'h0000,
  parameter logic [15:0] SERIAL_NUMBER = 16'h0000
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // acyclic request
  input wire logic req_valid,
  input wire drive_pkg::req_t req,
  output logic req_ready,
  // acyclic answer
  output logic rsp_valid,
  output drive_pkg::rsp_t rsp,
  // drive state
  input wire drive_pkg::status_flags_t status_flags,
  input wire logic signed [15:0] speed,
  input wire logic [15:0] torque,
  input wire logic [15:0] logic_supply,
  input wire logic [15:0] motor_supply,
  input wire logic signed [15:0] temperature,
  input wire logic [15:0] selector,
  // motion feedback
  input wire logic step_valid,
  input wire logic signed [15:0] step,
  input wire logic run_active,
  input wire logic start_phase,
  input wire logic brake_phase,
  // re-reference strobe toward the motion controller
  output logic reference_done
);

  // whether the parameter is four bytes wide
  function automatic logic is_wide(input logic [7:0] param);
    is_wide = (param == `PAR_POSITION);
  endfunction

  // length of a read answer
  function automatic logic [2:0] read_len(input logic [7:0] param);
    read_len = is_wide(param) ? `LEN_READ32 : `LEN_READ16;
  endfunction

  // length a write must carry, control byte included
  function automatic logic [2:0] write_len(input logic [7:0] param);
    write_len = is_wide(param) ? `LEN_WRITE32 : `LEN_WRITE16;
  endfunction

  function automatic logic is_known(input logic [7:0] param);
    case (param)
      `PAR_STATUS_FLAGS,
      `PAR_SPEED,
      `PAR_POSITION,
      `PAR_TORQUE,
      `PAR_PEAK_TORQUE,
      `PAR_LOGIC_SUPPLY,
      `PAR_MOTOR_SUPPLY,
      `PAR_TEMPERATURE,
      `PAR_SELECTOR,
      `PAR_MANUFACTURE,
      `PAR_SERIAL:
        is_known = 1'b1;
      default:
        is_known = 1'b0;
    endcase
  endfunction

  drive_pkg::bank_state_t state;
  drive_pkg::bank_state_t next_state;
  drive_pkg::req_t req_q;
  drive_pkg::req_t next_req_q;
  drive_pkg::rsp_t next_rsp;
  logic next_rsp_valid;
  logic next_req_ready;
  logic next_reference_done;
  logic load_position;
  logic [31:0] position;
  logic [15:0] peak_torque;
  logic [31:0] read_data;

  // outcome of the held request
  drive_pkg::rsp_code_t exec_code;
  logic exec_read;
  logic exec_load;

  position_counter u_position
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .step_valid(step_valid),
    .step(step),
    .load(load_position),
    .load_value(req_q.value),
    .position(position)
  );

  peak_torque_tracker u_peak
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .run_active(run_active),
    .start_phase(start_phase),
    .brake_phase(brake_phase),
    .torque(torque),
    .peak(peak_torque)
  );

  // read multiplexer, no side effects
  always_comb
  begin
    read_data = 32'h0000_0000;
    case (req_q.param)
      `PAR_STATUS_FLAGS:
      begin
        read_data = {16'h0000, status_flags};
      end
      `PAR_SPEED:
      begin
        read_data = {16'h0000, speed};
      end
      `PAR_POSITION:
      begin
        read_data = position;
      end
      `PAR_TORQUE:
      begin
        read_data = {16'h0000, torque};
      end
      `PAR_PEAK_TORQUE:
      begin
        read_data = {16'h0000, peak_torque};
      end
      `PAR_LOGIC_SUPPLY:
      begin
        read_data = {16'h0000, logic_supply};
      end
      `PAR_MOTOR_SUPPLY:
      begin
        read_data = {16'h0000, motor_supply};
      end
      `PAR_TEMPERATURE:
      begin
        read_data = {16'h0000, temperature};
      end
      `PAR_SELECTOR:
      begin
        read_data = {16'h0000, selector};
      end
      `PAR_MANUFACTURE:
      begin
        read_data = {16'h0000, MANUFACTURE_YYWW};
      end
      `PAR_SERIAL:
      begin
        read_data = {16'h0000, SERIAL_NUMBER};
      end
      default:
      begin
        read_data = 32'h0000_0000;
      end
    endcase
  end

  // outcome of the held request, in priority order
  always_comb
  begin
    exec_code = drive_pkg::RSP_OK;
    exec_read = 1'b0;
    exec_load = 1'b0;
    if (req_q.class_id != `DRV_CLASS || req_q.instance_id != `DRV_INSTANCE)
    begin
      exec_code = drive_pkg::RSP_BAD_OBJECT;
    end
    else if (!is_known(req_q.param))
    begin
      exec_code = drive_pkg::RSP_BAD_PARAM;
    end
    else if (!req_q.write)
    begin
      exec_read = 1'b1;
    end
    else if (req_q.len != write_len(req_q.param))
    begin
      exec_code = drive_pkg::RSP_BAD_LENGTH;
    end
    else if (req_q.ctrl == `CTRL_IGNORE)
    begin
      exec_code = drive_pkg::RSP_IGNORED;
    end
    else if (req_q.param != `PAR_POSITION)
    begin
      exec_code = drive_pkg::RSP_READ_ONLY;
    end
    else if (status_flags.drive_running)
    begin
      exec_code = drive_pkg::RSP_NOT_STANDSTILL;
    end
    else
    begin
      exec_load = 1'b1;
    end
  end

  // request sequencing
  always_comb
  begin
    next_state = state;
    next_req_q = req_q;
    next_rsp = rsp;
    next_rsp_valid = 1'b0;
    next_req_ready = req_ready;
    next_reference_done = 1'b0;
    load_position = 1'b0;
    case (state)
      drive_pkg::ST_IDLE:
      begin
        if (req_valid)
        begin
          next_req_q = req;
          next_req_ready = 1'b0;
          next_state = drive_pkg::ST_EXEC;
        end
      end
      drive_pkg::ST_EXEC:
      begin
        next_rsp.code = exec_code;
        next_rsp.data = exec_read ? read_data : 32'h0000_0000;
        next_rsp.len = exec_read ? read_len(req_q.param) : 3'h0;
        load_position = exec_load;
        next_reference_done = exec_load;
        next_rsp_valid = 1'b1;
        next_state = drive_pkg::ST_ANSWER;
      end
      drive_pkg::ST_ANSWER:
      begin
        next_req_ready = 1'b1;
        next_state = drive_pkg::ST_IDLE;
      end
      default:
      begin
        next_req_ready = 1'b1;
        next_state = drive_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state <= drive_pkg::ST_IDLE;
      req_q <= '0;
      rsp <= '0;
      rsp_valid <= 1'b0;
      req_ready <= 1'b1;
      reference_done <= 1'b0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      req_q <= next_req_q;
      rsp <= next_rsp;
      rsp_valid <= next_rsp_valid;
      req_ready <= next_req_ready;
      reference_done <= next_reference_done;
    end
  end

endmodule

// [tb/drive_bank_props.sv]
// Purpose: request/answer checker of the parameter bank
// Assumes: clk_en only dropped while the bank is idle
// Notes: request seen two edges before each answer
`timescale 1ns/1ps
`include "drive_defs.svh"
module drive_bank_props
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // request and answer
  input wire logic req_valid,
  input wire drive_pkg::req_t req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire drive_pkg::rsp_t rsp,
  input wire logic reference_done,
  // drive state
  input wire drive_pkg::status_flags_t status_flags
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic taken;
  assign taken = req_valid && req_ready && clk_en;
  a_answer_two: assert property (taken |=> !rsp_valid ##1 rsp_valid)
    else $error("answer not two edges after request");
  a_ready_gap: assert property (taken |=> !req_ready [*2] ##1 req_ready)
    else $error("ready gap wrong");
  a_pulse_once: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer strobe too long");
  a_ref_ok: assert property (reference_done |-> rsp_valid && rsp.code == drive_pkg::RSP_OK
    && $past(req.param, 2) == `PAR_POSITION && $past(req.ctrl, 2) != `CTRL_IGNORE) else $error("bad re-reference");
  a_ref_still: assert property (reference_done |-> !$past(status_flags.drive_running))
    else $error("re-reference while running");
  a_read_len: assert property (rsp_valid && rsp.code == drive_pkg::RSP_OK && !$past(req.write, 2) |->
    rsp.len == ($past(req.param, 2) == `PAR_POSITION ? `LEN_READ32 : `LEN_READ16)) else $error("read length");
  a_bad_object: assert property (rsp_valid && ($past(req.class_id, 2) != `DRV_CLASS
    || $past(req.instance_id, 2) != `DRV_INSTANCE) |-> rsp.code == drive_pkg::RSP_BAD_OBJECT) else $error("object");
  a_status_data: assert property (rsp_valid && rsp.code == drive_pkg::RSP_OK && !$past(req.write, 2)
    && $past(req.param, 2) == `PAR_STATUS_FLAGS |-> rsp.data == {16'h0000, $past(status_flags)}) else $error("flags");
  c_ref: cover property (reference_done);
  c_running: cover property (rsp_valid && rsp.code == drive_pkg::RSP_NOT_STANDSTILL);
  c_ignored: cover property (rsp_valid && rsp.code == drive_pkg::RSP_IGNORED);
endmodule
bind drive_status_parameter_bank drive_bank_props chk (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
  .reference_done(reference_done), .status_flags(status_flags));

// [tb/plc_model.sv]
// Purpose: acyclic requester standing in for the controller
// Assumes: one transfer at a time
// Notes: released request lines show the inverse pattern
`timescale 1ns/1ps
`include "drive_defs.svh"
module plc_model
(
  // clock
  input wire logic mclk,
  // request and answer
  output logic req_valid,
  output drive_pkg::req_t req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire drive_pkg::rsp_t rsp
);
  logic hung = 1'b0;
  initial
  begin
    req_valid = 1'b0;
    req = '0;
  end
  task automatic xfer(input logic wr, input logic [23:0] obj, input logic [31:0] val, input logic [7:0] ctl,
    input logic [2:0] ln, output drive_pkg::rsp_t got);
    int n;
    @(posedge mclk);
    #1;
    req_valid = 1'b1;
    req = '{wr, obj[23:16], obj[15:8], obj[7:0], ln, ctl, val};
    if (ln == 3'h0)
      req.len = obj[7:0] == `PAR_POSITION ? (wr ? `LEN_WRITE32 : 3'h4) : (wr ? `LEN_WRITE16 : 3'h2);
    n = 0;
    while (!req_ready && n < 20)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    hung |= !req_ready;
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    req = drive_pkg::req_t'(~req);
    n = 0;
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    while (!rsp_valid && n < 20);
    hung |= !rsp_valid;
    got = rsp;
  endtask
endmodule

// [tb/testbench.sv]
// Purpose: self-checking bench of the parameter bank
// Assumes: clock enable dropped only while idle
// Notes: table reads first, then hand cases
`timescale 1ns/1ps
`include "drive_defs.svh"
module testbench;
  typedef struct {logic [7:0] par; logic [2:0] ln; logic [31:0] dat;} row_t;
  localparam logic [15:0] OBJ = {`DRV_CLASS, `DRV_INSTANCE};
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic req_valid, req_ready, rsp_valid, reference_done;
  logic step_valid = 1'b0, run_active = 1'b0, start_phase = 1'b0, brake_phase = 1'b0;
  drive_pkg::req_t req;
  drive_pkg::rsp_t rsp, got;
  drive_pkg::status_flags_t status_flags = 16'h5a3c;
  logic [15:0] torque = 16'h0123, vlog = 16'h00f0, vmot = 16'h01e0, sel = 16'h0007;
  logic signed [15:0] spd = 16'shff38, tmp = 16'shfffb, step = 16'sh0019;
  int fails = 0;
  int n_checks = 0;
  int n_ref = 0;
  row_t rows[11] = '{'{8'h08, 3'h2, 32'h0000_5a3c}, '{8'h09, 3'h2, 32'h0000_ff38}, '{8'h0a, 3'h4, 32'h0000_0000},
    '{8'h0e, 3'h2, 32'h0000_0123}, '{8'h0f, 3'h2, 32'h0000_0000}, '{8'h10, 3'h2, 32'h0000_00f0},
    '{8'h11, 3'h2, 32'h0000_01e0}, '{8'h12, 3'h2, 32'h0000_fffb}, '{8'h13, 3'h2, 32'h0000_0007},
    '{8'h14, 3'h2, 32'h0000_0961}, '{8'h15, 3'h2, 32'h0000_1234}};
  logic [18:0] ph[5] = '{{3'b110, 16'h0900}, {3'b100, 16'h0300}, {3'b100, 16'h0500}, {3'b101, 16'h0800},
    {3'b000, 16'h0050}};
  always #4 mclk = ~mclk;
  // re-reference strobes, counted where settled
  always @(negedge mclk)
  begin
    if (reference_done === 1'b1)
      n_ref++;
  end
  plc_model plc (.mclk(mclk), .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp(rsp));
  // serial value arbitrary
  drive_status_parameter_bank #(.MANUFACTURE_YYWW(16'h0961), .SERIAL_NUMBER(16'h1234)) dut (.mclk(mclk),
    .sys_rst(sys_rst), .clk_en(clk_en), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .status_flags(status_flags), .speed(spd), .torque(torque),
    .logic_supply(vlog), .motor_supply(vmot), .temperature(tmp), .selector(sel), .step_valid(step_valid),
    .step(step), .run_active(run_active), .start_phase(start_phase), .brake_phase(brake_phase),
    .reference_done(reference_done));
  task automatic check(input string nm, input logic [37:0] exp, input logic [37:0] seen);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic op(input logic wr, input logic [23:0] obj, input logic [31:0] val, input logic [7:0] ctl,
    input logic [2:0] ln, input string nm, input logic [37:0] exp);
    plc.xfer(wr, obj, val, ctl, ln, got);
    check(nm, exp, got);
    if (plc.hung)
      finish_test();
  endtask
  task automatic finish_test();
    if (plc.hung)
      fails++;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    check("ready after reset", 38'h1, {37'h0, req_ready});
    check("answer after reset", 38'h0, rsp);
    foreach (rows[i])
      op(0, {OBJ, rows[i].par}, 0, 8'h00, 0, "table read", {drive_pkg::RSP_OK, rows[i].ln, rows[i].dat});
    op(0, {8'h65, 8'h01, 8'h08}, 0, 8'h00, 0, "class", {drive_pkg::RSP_BAD_OBJECT, 35'h0});
    op(0, {8'h64, 8'h02, 8'h08}, 0, 8'h00, 0, "instance", {drive_pkg::RSP_BAD_OBJECT, 35'h0});
    op(1, {OBJ, 8'h08}, 32'h0000_ffff, 8'h01, 0, "ro write", {drive_pkg::RSP_READ_ONLY, 35'h0});
    op(0, {OBJ, 8'h08}, 0, 8'h00, 0, "flags kept", {drive_pkg::RSP_OK, 3'h2, 32'h0000_5a3c});
    op(1, {OBJ, 8'h0a}, 32'h0000_0100, 8'h00, 0, "zero ctrl", {drive_pkg::RSP_IGNORED, 35'h0});
    op(1, {OBJ, 8'h0a}, 32'h0000_0100, 8'h01, 3'h3, "short write", {drive_pkg::RSP_BAD_LENGTH, 35'h0});
    status_flags.drive_running = 1'b1;
    op(1, {OBJ, 8'h0a}, 32'h0000_0100, 8'h01, 0, "moving", {drive_pkg::RSP_NOT_STANDSTILL, 35'h0});
    status_flags.drive_running = 1'b0;
    op(0, {OBJ, 8'h0a}, 0, 8'h00, 0, "pos kept", {drive_pkg::RSP_OK, 3'h4, 32'h0000_0000});
    op(1, {OBJ, 8'h0a}, 32'hffff_fc18, 8'h01, 0, "re-reference", {drive_pkg::RSP_OK, 35'h0});
    op(0, {OBJ, 8'h0a}, 0, 8'h00, 0, "pos loaded", {drive_pkg::RSP_OK, 3'h4, 32'hffff_fc18});
    step_valid = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    step_valid = 1'b0;
    op(0, {OBJ, 8'h0a}, 0, 8'h00, 0, "pos stepped", {drive_pkg::RSP_OK, 3'h4, 32'hffff_fc7c});
    @(posedge mclk);
    #1;
    clk_en = 1'b0;
    step_valid = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    clk_en = 1'b1;
    step_valid = 1'b0;
    op(0, {OBJ, 8'h0a}, 0, 8'h00, 0, "pos frozen", {drive_pkg::RSP_OK, 3'h4, 32'hffff_fc7c});
    foreach (ph[i])
    begin
      {run_active, start_phase, brake_phase, torque} = ph[i];
      repeat (3) @(posedge mclk);
      #1;
    end
    op(0, {OBJ, 8'h0f}, 0, 8'h00, 0, "peak torque", {drive_pkg::RSP_OK, 3'h2, 32'h0000_0500});
    check("re-reference strobes", 38'h1, 38'(n_ref));
    finish_test();
  end
endmodule
